//--- rtl/general_timer_unit.sv
// five-timer general purpose timer unit with an AHB-Lite register port
`timescale 1ns/1ps
`include "general_timer_unit_regs.svh"
//
// What this block does
// - five 16-bit timers in two groups
// - timers run alone or chained within group
// - group one: timer, gated, counter, quadrature
// - timer mode counts prescaled system clock
// - counter mode counts input pin events
// - gated mode counts while gate pin high
// - group one finest step four clocks
// - direction by software or direction pin
// - quadrature phases give count and direction
// - core toggle latch flips on wrap
// - core latch can clock either auxiliary
// - capture/reload auxiliary stops counting
// - capture copies core on auxiliary pin event
// - reload core on pin or latch transition
// - two auxiliaries alternate reloads for waveforms
// - some auxiliary inputs have no pins
// - group two: two timers, register, two clocks
// - group two prescaled clock or external input
// - group two latch clocks aux, drives pin
// - group two wrap pulses out, reloads core
// - capture pin latches aux, optional clear
// - capture also from core count/direction pins

module general_timer_unit
   import general_timer_unit_pkg::*;
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // asynchronous reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size, word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // response, always okay
   input wire pins_s pins, // gate, count and direction pins
   output logic core_toggle_output, // group one toggle latch pin
   output logic group_two_toggle_output, // group two toggle latch pin
   output logic group_two_core_overflow // wrap pulse for compare timers
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // transition detect: sel[0] rising, sel[1] falling
   function automatic logic edge_hit(logic old_v, logic new_v,
                                     logic [1:0] sel);
      edge_hit = (sel[0] & ~old_v & new_v) | (sel[1] & old_v & ~new_v);
   endfunction

   // prescaler tick once every 2**shift clocks
   function automatic logic pre_tick(logic [9:0] pre, logic [3:0] shift);
      logic [9:0] mask;
      mask = 10'((11'h001 << shift) - 11'h001);
      pre_tick = (pre & mask) == mask;
   endfunction

   // one count step; bit 16 flags the wrap in either direction
   function automatic logic [16:0] step(logic [15:0] v, logic dn);
      step = dn ? ({1'b0, v} - 17'h00001) : ({1'b0, v} + 17'h00001);
   endfunction

   // byte offset of a per-timer register
   function automatic logic [5:0] ofs(logic [5:0] base, int i);
      ofs = base + 6'(4 * i);
   endfunction

   // word number of the register an address selects: 0..4 control,
   // 5..9 counters, 10 capture/reload, 11 group two control, 12
   // latches; 15 for any place holding no register, so a refused
   // access is recognised in one spot for both directions
   function automatic logic [3:0] reg_index(logic [31:0] a);
      reg_index = 4'hf;
      if (a[31:6] == 26'h0) begin
         for (int i = 0; i < 5; i++) begin
            if (a[5:0] == ofs(`OFS_CTRL_BASE, i)) begin
               reg_index = 4'(i);
            end
            if (a[5:0] == ofs(`OFS_CNT_BASE, i)) begin
               reg_index = 4'(i + 5);
            end
         end
         if (a[5:0] == `OFS_CAPTURE_RELOAD_REG) begin
            reg_index = 4'ha;
         end
         if (a[5:0] == `OFS_G2_CTRL) begin
            reg_index = 4'hb;
         end
         if (a[5:0] == `OFS_LATCH) begin
            reg_index = 4'hc;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   // one aligned 32-bit word per register, value in the low half:
   //   0x00..0x10 control of first aux, core, second aux, group two
   //              aux and group two core, in that order
   //   0x14..0x24 the five counters, same order
   //   0x28 capture/reload register
   //   0x2c group two capture control: [1:0] edge, [3:2] source,
   //        4 clear after capture, 5 reload core on wrap
   //   0x30 toggle latches, bit 0 group one, bit 1 group two
   // control word: [1:0] mode, 2 run, 3 down, 4 direction pin
   // enable, [7:5] prescale, [9:8] auxiliary function, [11:10] edge
   // select, 12 toggle latch as source, 13 toggle output enable

   // ----------------------------------------------------------------
   // state and pin views
   // ----------------------------------------------------------------
   state_s s;
   state_s next_s;
   logic [4:0] in_now;
   logic [4:0] in_old;
   logic [4:0] dir_now;
   logic [4:0] dir_old;
   logic [4:0] ev;
   logic [4:0] dn;
   logic [4:0] wrap;
   logic [15:0] c;
   logic [16:0] r;
   logic [31:0] rd;
   logic [1:0] e;
   logic g1;
   logic lsrc;
   logic trig;
   logic cap;
   logic accept;
   logic [3:0] aidx;
   logic [3:0] widx;

   // pins are taken as synchronous to hclk; a level that lasts less
   // than one clock may be missed entirely
   // first aux has neither count nor direction pin, second aux and
   // group two core have no direction pin: tied low here
   assign in_now = {pins.group_two_core_count_input,
                    pins.group_two_aux_count_input,
                    pins.second_aux_count_input,
                    pins.core_count_input, 1'b0};
   assign in_old = {s.pins_old.group_two_core_count_input,
                    s.pins_old.group_two_aux_count_input,
                    s.pins_old.second_aux_count_input,
                    s.pins_old.core_count_input, 1'b0};
   assign dir_now = {1'b0, pins.group_two_aux_direction_input, 1'b0,
                     pins.core_direction_input, 1'b0};
   assign dir_old = {1'b0, s.pins_old.group_two_aux_direction_input,
                     1'b0, s.pins_old.core_direction_input, 1'b0};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------

   // index 0 first aux, 1 core, 2 second aux, 3 group two aux,
   // 4 group two core
   always_comb begin
      next_s = s;
      ev = '0;
      dn = '0;
      wrap = '0;
      c = '0;
      r = '0;
      rd = '0;
      e = '0;
      g1 = 1'b0;
      lsrc = 1'b0;
      trig = 1'b0;
      cap = 1'b0;
      aidx = 4'hf;
      widx = 4'hf;
      next_s.pins_old = pins;
      next_s.pre = s.pre + 10'h001;
      next_s.ovf = 1'b0;
      next_s.tl_d = s.tl;

      // per-timer count events; five 16-bit counters
      for (int i = 0; i < 5; i++) begin
         c = s.ctrl[i];
         g1 = (i < 3);
         e = c[`F_EDGE +: 2];
         // only auxiliaries may take the toggle latch as source
         lsrc = c[`F_LATCH_SRC] & (i != 1) & (i != 4);
         dn[i] = c[`F_DOWN] ^ (c[`F_EXT_DIR] & dir_now[i]);
         // group one steps at 4 << pre, group two at 2 << pre; the
         // prescaler is shared and free running, so the first step
         // after a start may come up to one period early
         trig = c[`F_RUN] & pre_tick(s.pre, 4'(c[`F_PRE +: 3]) +
                (g1 ? `G1_DIV_LOG2 : `G2_DIV_LOG2));
         case (mode_e'(c[`F_MODE +: 2]))
            MODE_TIMER: begin
               ev[i] = trig;
            end
            MODE_GATED: begin
               ev[i] = trig & in_now[i];
            end
            MODE_COUNTER: begin
               if (lsrc) begin
                  // chaining through the group's toggle latch
                  ev[i] = c[`F_RUN] & edge_hit(s.tl_d[g1 ? 0 : 1],
                          s.tl[g1 ? 0 : 1], e);
               end else begin
                  ev[i] = c[`F_RUN] &
                          edge_hit(in_old[i], in_now[i], e);
               end
            end
            MODE_QUAD: begin
               if (g1) begin
                  // any phase change counts; phase order gives sense
                  // a sensor jumping two phases in one clock miscounts
                  ev[i] = c[`F_RUN] & ((in_old[i] ^ in_now[i]) |
                          (dir_old[i] ^ dir_now[i]));
                  dn[i] = c[`F_DOWN] ^ ~(in_old[i] ^ dir_now[i]);
               end else begin
                  ev[i] = c[`F_RUN] & edge_hit(in_old[i], in_now[i], e);
               end
            end
            default: begin
               ev[i] = 1'b0;
            end
         endcase
         // an auxiliary used as capture/reload register is stopped
         if (((i == 0) || (i == 2)) &&
             (func_e'(c[`F_FUNC +: 2]) != FN_COUNT)) begin
            ev[i] = 1'b0;
         end
         r = step(s.cnt[i], dn[i]);
         if (ev[i]) begin
            next_s.cnt[i] = r[15:0];
            wrap[i] = r[16];
         end
      end

      // toggle latches flip on every wrap of their core timer
      if (wrap[1]) begin
         next_s.tl[0] = ~s.tl[0];
      end
      if (wrap[4]) begin
         next_s.tl[1] = ~s.tl[1];
         next_s.ovf = 1'b1;
         // a reload on wrap replaces the wrapped value in that clock
         if (s.g2_ctrl[`F_CAP_RELOAD]) begin
            next_s.cnt[4] = s.capture_reload_reg;
         end
      end

      // group one auxiliaries as reload or capture registers; the
      // latch transition is seen one clock after the wrap, which is
      // below the four-clock count step so no count is lost
      for (int j = 0; j < 3; j += 2) begin
         c = s.ctrl[j];
         e = c[`F_EDGE +: 2];
         if (c[`F_LATCH_SRC]) begin
            trig = edge_hit(s.tl_d[0], s.tl[0], e);
         end else begin
            trig = edge_hit(in_old[j], in_now[j], e);
         end
         // opposite latch edges on the two auxiliaries alternate the
         // low and high times without software help
         if ((func_e'(c[`F_FUNC +: 2]) == FN_RELOAD) && trig) begin
            next_s.cnt[1] = s.cnt[j];
         end
         if ((func_e'(c[`F_FUNC +: 2]) == FN_CAPTURE) &&
             edge_hit(in_old[j], in_now[j], e)) begin
            next_s.cnt[j] = s.cnt[1];
         end
      end

      // group two capture: own pin, or core count/direction pins
      e = s.g2_ctrl[`F_CAP_EDGE +: 2];
      if (s.g2_ctrl[`F_CAP_SRC +: 2] == 2'b00) begin
         cap = edge_hit(s.pins_old.capture_trigger_input,
                        pins.capture_trigger_input, e);
      end else begin
         cap = (s.g2_ctrl[`F_CAP_SRC] &
                edge_hit(in_old[1], in_now[1], e)) |
               (s.g2_ctrl[`F_CAP_SRC + 1] &
                edge_hit(dir_old[1], dir_now[1], e));
      end
      if (cap) begin
         next_s.capture_reload_reg = s.cnt[3];
         if (s.g2_ctrl[`F_CAP_CLR]) begin
            next_s.cnt[3] = `CNT_RST;
         end
      end

      // bus data phase write; software write beats a same-cycle
      // hardware update of the same register
      if (s.wr_pend) begin
         widx = reg_index({26'h0, s.addr});
         for (int i = 0; i < 5; i++) begin
            if (widx == 4'(i)) begin
               next_s.ctrl[i] = hwdata[15:0];
            end
            if (widx == 4'(i + 5)) begin
               next_s.cnt[i] = hwdata[15:0];
            end
         end
         if (widx == 4'ha) begin
            next_s.capture_reload_reg = hwdata[15:0];
         end
         if (widx == 4'hb) begin
            next_s.g2_ctrl = hwdata[7:0];
         end
         if (widx == 4'hc) begin
            next_s.tl = hwdata[1:0];
         end
      end

      // pins take the latch state at the edge it flips, via a flop
      next_s.tout[0] = next_s.tl[0] & next_s.ctrl[1][`F_OUT_EN];
      next_s.tout[1] = next_s.tl[1] & next_s.ctrl[4][`F_OUT_EN];

      // bus address phase; read data is taken from the updated state
      // so a read right after a write sees the new value
      accept = hsel & hready & htrans[1];
      aidx = reg_index(haddr);
      next_s.wr_pend = accept & hwrite & (aidx != 4'hf);
      next_s.addr = haddr[5:0];
      next_s.rdy = 1'b1;
      next_s.resp = 1'b0;
      // a refused read still answers, with an all-zero word
      if (accept && !hwrite) begin
         for (int i = 0; i < 5; i++) begin
            if (aidx == 4'(i)) begin
               rd = {16'h0000, next_s.ctrl[i]};
            end
            if (aidx == 4'(i + 5)) begin
               rd = {16'h0000, next_s.cnt[i]};
            end
         end
         if (aidx == 4'ha) begin
            rd = {16'h0000, next_s.capture_reload_reg};
         end
         if (aidx == 4'hb) begin
            rd = {24'h000000, next_s.g2_ctrl};
         end
         if (aidx == 4'hc) begin
            rd = {30'h0, next_s.tl};
         end
         next_s.rdata = rd;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------

   // the clock enable also stalls the bus side: keep it high for
   // register access or a write in that cycle is lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.rdy <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // all outputs straight from the state flops
   assign hrdata = s.rdata;
   assign hreadyout = s.rdy;
   assign hresp = s.resp;
   assign core_toggle_output = s.tout[0];
   assign group_two_toggle_output = s.tout[1];
   assign group_two_core_overflow = s.ovf;

endmodule

//--- rtl/general_timer_unit_pkg.sv
// types shared by the general timer unit
package general_timer_unit_pkg;

   // gray-ordered count modes
   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_GATED = 2'b01,
      MODE_COUNTER = 2'b11,
      MODE_QUAD = 2'b10
   } mode_e;

   // auxiliary timer function
   typedef enum logic [1:0] {
      FN_COUNT = 2'b00,
      FN_RELOAD = 2'b01,
      FN_CAPTURE = 2'b11
   } func_e;

   // external pins that reach the unit
   typedef struct packed {
      logic core_count_input;
      logic core_direction_input;
      logic second_aux_count_input;
      logic group_two_aux_count_input;
      logic group_two_aux_direction_input;
      logic group_two_core_count_input;
      logic capture_trigger_input;
   } pins_s;

   // whole state of the unit
   typedef struct packed {
      logic [4:0][15:0] cnt;
      logic [4:0][15:0] ctrl;
      logic [15:0] capture_reload_reg;
      logic [7:0] g2_ctrl;
      logic [1:0] tl;
      logic [1:0] tl_d;
      logic [1:0] tout;
      logic ovf;
      logic [9:0] pre;
      pins_s pins_old;
      logic wr_pend;
      logic [5:0] addr;
      logic [31:0] rdata;
      logic rdy;
      logic resp;
   } state_s;

endpackage

//--- rtl/general_timer_unit_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef GENERAL_TIMER_UNIT_REGS_SVH
`define GENERAL_TIMER_UNIT_REGS_SVH

// ----------------------------------------------------------------
// byte offsets (one aligned 32-bit word per register)
// ----------------------------------------------------------------
`define OFS_CTRL_BASE 6'h00
`define OFS_CNT_BASE 6'h14
`define OFS_CAPTURE_RELOAD_REG 6'h28
`define OFS_G2_CTRL 6'h2c
`define OFS_LATCH 6'h30

// ----------------------------------------------------------------
// per-timer control word fields
// ----------------------------------------------------------------
`define F_MODE 0
`define F_RUN 2
`define F_DOWN 3
`define F_EXT_DIR 4
`define F_PRE 5
`define F_FUNC 8
`define F_EDGE 10
`define F_LATCH_SRC 12
`define F_OUT_EN 13

// ----------------------------------------------------------------
// group two capture control fields
// ----------------------------------------------------------------
`define F_CAP_EDGE 0
`define F_CAP_SRC 2
`define F_CAP_CLR 4
`define F_CAP_RELOAD 5

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define CTRL_RST 16'h0000
`define CNT_RST 16'h0000
`define G1_DIV_LOG2 4'h2
`define G2_DIV_LOG2 4'h1

`endif

//--- test/general_timer_unit_bench.sv
// self-checking bench of the general timer unit
`timescale 1ns/1ps
module general_timer_unit_bench
   import general_timer_unit_pkg::*;
();
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ce = 1;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r, r0;
   logic hreadyout, hresp, cto, gto, ovf;
   logic [6:0] lvl = 0;
   logic q_en = 0, q_step = 0, q_back = 0;
   logic [15:0] v;
   logic [15:0] mdl [13];
   pins_s pins;
   int err_count = 0, tests_run = 0, cyc = 0, ovf_seen = 0, d, st;
   int tix [7] = '{1, 1, 1, 4, 4, 1, 1};
   logic [15:0] tcw [7] = '{16'h0004, 16'h002c, 16'h0014, 16'h0004,
      16'h004c, 16'h0005, 16'h0005};
   logic [6:0] tpl [7] = '{7'h0, 7'h0, 7'h20, 7'h0, 7'h0, 7'h0, 7'h40};
   general_timer_unit dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
      .core_toggle_output(cto), .group_two_toggle_output(gto),
      .group_two_core_overflow(ovf));
   pin_partner far (.hclk(hclk), .hresetn(hresetn), .lvl(lvl),
      .q_en(q_en), .q_step(q_step), .q_back(q_back), .pins(pins));
   always #50 hclk = ~hclk;
   // hang limit, and a tally of wrap pulses
   always @(posedge hclk) begin
      cyc++;
      if (ovf === 1'b1) ovf_seen++;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // one single transfer; starts just after an edge, ends at one
   task automatic bus(logic w, logic [31:0] a, logic [15:0] dt);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {16'h0, dt};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      if (w && a < 32'h34) mdl[a[5:2]] = dt;
   endtask
   task automatic rd(logic [31:0] a);
      bus(1'b0, a, 16'h0);
      chk("register", a < 32'h34 ? mdl[a[5:2]] : 16'h0, r[15:0]);
   endtask
   task automatic pulse(int b);
      lvl[b] <= 1'b1;
      repeat (3) @(posedge hclk);
      lvl[b] <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask
   task automatic qstep(logic b);
      q_step <= 1'b1;
      q_back <= b;
      @(posedge hclk);
      q_step <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask
   initial begin
      foreach (mdl[i]) mdl[i] = 16'h0;
      void'($urandom(32'h22731aa7));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values, an unmapped place, control words kept idle
      for (int i = 0; i < 13; i++) rd(4 * i);
      bus(1'b1, 32'h40, 16'hffff);
      rd(32'h40);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 4 * i, 16'($urandom) & 16'h3ffb);
         rd(4 * i);
         rd(32'h40);
         bus(1'b1, 4 * i, 16'h0);
      end
      // counts over a 40-cycle span: prescaler, direction, gate
      foreach (tix[k]) begin
         lvl <= tpl[k];
         bus(1'b1, 4 * tix[k], tcw[k]);
         bus(1'b0, 32'h14 + 4 * tix[k], 16'h0);
         r0 = r;
         repeat (38) @(posedge hclk);
         bus(1'b0, 32'h14 + 4 * tix[k], 16'h0);
         st = (tix[k] < 3 ? 4 : 2) << tcw[k][7:5];
         d = 40 / st;
         if (tcw[k][1:0] == 2'b01 && !tpl[k][6]) d = 0;
         if (tcw[k][3] ^ (tcw[k][4] & tpl[k][5])) d = -d;
         chk("span", r0[15:0] + d[15:0], r[15:0]);
         bus(1'b1, 4 * tix[k], 16'h0);
      end
      // clock enable low freezes prescaler and counter: two live
      // prescaler steps at the two-clock rate give exactly one count
      bus(1'b1, 32'h10, 16'h0004);
      bus(1'b0, 32'h24, 16'h0);
      r0 = r;
      ce <= 1'b0;
      repeat (40) @(posedge hclk);
      ce <= 1'b1;
      bus(1'b0, 32'h24, 16'h0);
      chk("frozen", r0[15:0] + 16'h0001, r[15:0]);
      bus(1'b1, 32'h10, 16'h0);
      // rising, then both edges, then sensor steps on the core
      lvl <= 7'h0;
      bus(1'b1, 32'h18, 16'h0);
      bus(1'b1, 32'h04, 16'h0407);
      repeat (5) pulse(6);
      bus(1'b1, 32'h04, 16'h0c07);
      repeat (3) pulse(6);
      bus(1'b1, 32'h04, 16'h0006);
      q_en <= 1'b1;
      repeat (7) qstep(1'b0);
      repeat (3) qstep(1'b1);
      mdl[6] = 16'd15;
      rd(32'h18);
      bus(1'b1, 32'h04, 16'h0);
      q_en <= 1'b0;
      // underflow flips the latch, which clocks the second auxiliary
      bus(1'b1, 32'h30, 16'h0);
      bus(1'b1, 32'h1c, 16'h0);
      bus(1'b1, 32'h08, 16'h1c07);
      bus(1'b1, 32'h18, 16'h0);
      bus(1'b1, 32'h04, 16'h240f);
      pulse(6);
      mdl[6] = 16'hffff;
      mdl[7] = 16'h0001;
      mdl[12] = 16'h0001;
      rd(32'h18);
      rd(32'h1c);
      rd(32'h30);
      chk("core pin", 16'h1, {15'h0, cto});
      bus(1'b1, 32'h04, 16'h0);
      // capture and reload through the second auxiliary
      v = 16'($urandom);
      bus(1'b1, 32'h18, v);
      bus(1'b1, 32'h08, 16'h0704);
      pulse(4);
      repeat (40) @(posedge hclk);
      mdl[7] = v;
      rd(32'h1c);
      bus(1'b1, 32'h08, 16'h0504);
      bus(1'b1, 32'h1c, ~v);
      pulse(4);
      mdl[6] = ~v;
      rd(32'h18);
      bus(1'b1, 32'h08, 16'h0);
      // group two capture, with clear, then from the core pin
      bus(1'b1, 32'h20, 16'h0abc);
      bus(1'b1, 32'h2c, 16'h0011);
      pulse(0);
      mdl[10] = 16'h0abc;
      mdl[8] = 16'h0;
      rd(32'h28);
      rd(32'h20);
      bus(1'b1, 32'h20, 16'h0555);
      bus(1'b1, 32'h2c, 16'h0005);
      pulse(6);
      mdl[10] = 16'h0555;
      rd(32'h28);
      // group two wrap: reload, latch, pin, pulse, chained count
      bus(1'b1, 32'h20, 16'h0);
      bus(1'b1, 32'h0c, 16'h1c07);
      bus(1'b1, 32'h2c, 16'h0020);
      bus(1'b1, 32'h24, 16'hffff);
      bus(1'b1, 32'h10, 16'h2407);
      pulse(1);
      mdl[9] = 16'h0555;
      mdl[8] = 16'h0001;
      mdl[12] = 16'h0003; // group one latch still set from underflow
      rd(32'h24);
      rd(32'h20);
      rd(32'h30);
      chk("wrap pulses", 16'h1, ovf_seen[15:0]);
      chk("group two pin", 16'h1, {15'h0, gto});
      finish_test();
   end
endmodule

//--- test/pin_partner.sv
// pin-side model: level pins and a quadrature position sensor
`timescale 1ns/1ps
module pin_partner
   import general_timer_unit_pkg::*;
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // reset, active low
   input wire logic [6:0] lvl, // requested pin levels
   input wire logic q_en, // sensor owns the core pins
   input wire logic q_step, // move the sensor one phase
   input wire logic q_back, // move it backwards
   output pins_s pins // pins toward the unit
);
   logic [1:0] ph;
   pins_s nxt;
   // sensor phases follow a gray order, so one line changes per step
   always_comb begin
      nxt = lvl;
      if (q_en) begin
         nxt.core_count_input = ph[1];
         nxt.core_direction_input = ph[1] ^ ph[0];
      end
   end
   // pins change only just after a clock edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 2'b00;
         pins <= '0;
      end else begin
         pins <= nxt;
         if (q_step) ph <= q_back ? ph - 2'b01 : ph + 2'b01;
      end
   end
endmodule

//--- test/timer_unit_properties.sv
// bus and pin properties of the general timer unit
`timescale 1ns/1ps
module timer_unit_properties (
   input wire logic hclk, // system clock
   input wire logic hresetn, // reset, active low
   input wire logic ce, // clock enable
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write strobe
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   input wire logic [31:0] hrdata, // read data
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic core_toggle_output, // group one latch pin
   input wire logic group_two_toggle_output // group two latch pin
);
   logic acc;
   logic wp;
   logic [31:0] wa;
   logic en1;
   logic en2;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // an accepted address phase
   assign acc = ce && hsel && hready && htrans[1];
   // shadow of the output enables, since both pins are gated by them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp <= 1'b0;
         wa <= 32'h0;
         en1 <= 1'b0;
         en2 <= 1'b0;
      end else if (ce) begin
         wp <= acc && hwrite;
         wa <= haddr;
         if (wp && wa == 32'h04) en1 <= hwdata[13];
         if (wp && wa == 32'h10) en2 <= hwdata[13];
      end
   end
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_ready_high: assert property (hreadyout)
      else $error("wait state inserted");
   a_unmapped_zero: assert property (
      acc && !hwrite && haddr > 32'h30 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (
      acc && !hwrite |=> hrdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   a_rdata_holds: assert property (
      !(acc && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_ctrl_back: assert property (
      (acc && hwrite && haddr < 32'h14) ##2
      (acc && !hwrite && haddr == $past(haddr, 2))
      |=> hrdata[13:0] == $past(hwdata[13:0]))
      else $error("control word not read back");
   a_core_gate: assert property (
      core_toggle_output |-> en1 || $past(en1))
      else $error("core pin high while disabled");
   a_two_gate: assert property (
      group_two_toggle_output |-> en2 || $past(en2))
      else $error("group two pin high while disabled");
endmodule

bind general_timer_unit timer_unit_properties chk (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .core_toggle_output(core_toggle_output),
   .group_two_toggle_output(group_two_toggle_output)
);
